// ==== hw/scgu_top.sv ====
// Clock generation unit: source select, halving paths, derived clock enables.
// Assumes all pins are synchronous to CLK; CLK stands for the system bus clock.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "scgu_params.svh"

// Summary of operation
// - Host mode takes the host primary clock input as source.
// - Agent mode takes the bus clock pin; board grounds host input.
// - Source is halved; reset-time select picks full or half for sync output.
// - Each bus clock output has its own full/half select bit.
// - System bus ratio is (one plus halving select) times PLL multiplier.
// - Core clock multiplier comes from the processor PLL field.
// - Multipliers load from config word pins or the built-in option.
// - Memory clock ratio is one plus mode bit; pair toggles every cycle, giving half rate.
// - Local bus clocks run at half, quarter or eighth per divide field.
// - Five unit groups default to one third; may be off, full, half, third.
// - Bus and DMA complex defaults to full rate; only other choice is off.
// - Multiplier code 0 means 16, code 1 reserved, others their value.
module scgu_top #(
    parameter int NUM_BUS_OUT = 5,
    parameter int NUM_UNITS = 5
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Straps and pins
    input wire logic HOST_MODE,
    input wire logic HOST_PRIMARY_CLOCK_INPUT,
    input wire logic PCI_CLK_IN,
    input wire logic INPUT_HALVING_SELECT,
    input wire logic [15:0] RESET_CONFIG_WORD_LOW,
    input wire logic USE_BUILTIN_CONFIG,
    input wire logic PLL_LOCK,
    // AXI4-Lite slave
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Clock outputs
    output logic PCI_SYNC_OUT,
    output logic [NUM_BUS_OUT-1:0] BUS_CLOCK_OUTPUT_N,
    output logic [1:0] MEMORY_BUS_CLOCK_PAIR,
    output logic LOCAL_BUS_SYNC_OUTPUT,
    output logic [2:0] LOCAL_BUS_CLOCK_OUTPUTS,
    output logic [NUM_UNITS-1:0] UNIT_CLK_EN,
    output logic PCI_DMA_CLK_EN,
    // Ratios
    output logic [5:0] CSB_RATIO,
    output logic [3:0] CORE_MULT,
    output logic [1:0] DDR_RATIO,
    output logic [1:0] LBIU_RATIO,
    output logic SYSTEM_PLL_MULTIPLIER_FIELD_RESERVED
);
    initial begin
        if (NUM_BUS_OUT < 1 || NUM_BUS_OUT > 8 || NUM_UNITS != 5)
            $error("scgu_top: unsupported parameter values");
    end

    scgu_pkg::scgu_state_type state;
    scgu_pkg::scgu_cfg_type cfg;
    logic [15:0] word;
    logic prim;
    logic prim_d;
    logic half;
    logic gate;
    logic [NUM_BUS_OUT-1:0] output_clock_control_register;
    logic [10:0] system_clock_config_register;
    logic [1:0] local_bus_clock_config_register;
    logic [2:0] lb_cnt;
    logic lb_bit;
    logic [4:0] mult;
    logic wr_go;
    logic [31:0] rd_word;
    logic rd_ok;

    // Gating follows lock so a lost lock stops the derived clocks again
    assign gate = (state == scgu_pkg::SCGU_RUN) && PLL_LOCK;
    assign word = USE_BUILTIN_CONFIG ? `SCGU_BUILTIN_RESET_CONFIG_WORD_LOW : RESET_CONFIG_WORD_LOW;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= scgu_pkg::SCGU_HOLD;
        end else begin
            case (state)
                scgu_pkg::SCGU_HOLD: state <= scgu_pkg::SCGU_LATCH;
                scgu_pkg::SCGU_LATCH: state <= scgu_pkg::SCGU_WAIT_LOCK;
                scgu_pkg::SCGU_WAIT_LOCK: if (PLL_LOCK) state <= scgu_pkg::SCGU_RUN;
                scgu_pkg::SCGU_RUN: if (!PLL_LOCK) state <= scgu_pkg::SCGU_WAIT_LOCK;
                default: state <= scgu_pkg::SCGU_HOLD;
            endcase
        end
    end

    // Straps caught on the second edge after release, never under reset itself
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cfg <= '0;
        end else if (state == scgu_pkg::SCGU_LATCH) begin
            cfg.host_mode <= HOST_MODE;
            cfg.host_primary_clock_input_div <= INPUT_HALVING_SELECT;
            cfg.system_pll_multiplier_field <= word[`SCGU_SYSTEM_PLL_MULTIPLIER_FIELD_LSB +: 4];
            cfg.core <= word[`SCGU_CORE_LSB +: 4];
            cfg.memory_clock_mode_bit <= word[`SCGU_MEMORY_CLOCK_MODE_BIT_BIT];
            cfg.local_bus_clock_mode_bit <= word[`SCGU_LOCAL_BUS_CLOCK_MODE_BIT_BIT];
        end
    end

    assign mult = (cfg.system_pll_multiplier_field == `SCGU_SYSTEM_PLL_MULTIPLIER_FIELD_X16) ? `SCGU_MULT_16 : {1'b0, cfg.system_pll_multiplier_field};

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            CSB_RATIO <= '0;
            CORE_MULT <= '0;
            DDR_RATIO <= '0;
            LBIU_RATIO <= '0;
            SYSTEM_PLL_MULTIPLIER_FIELD_RESERVED <= 1'b0;
        end else begin
            CSB_RATIO <= cfg.host_primary_clock_input_div ? {mult, 1'b0} : {1'b0, mult};
            CORE_MULT <= cfg.core;
            DDR_RATIO <= cfg.memory_clock_mode_bit ? 2'h2 : 2'h1;
            LBIU_RATIO <= cfg.local_bus_clock_mode_bit ? 2'h2 : 2'h1;
            SYSTEM_PLL_MULTIPLIER_FIELD_RESERVED <= (cfg.system_pll_multiplier_field == `SCGU_SYSTEM_PLL_MULTIPLIER_FIELD_RSVD);
        end
    end

    // Primary source and its halved copy
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prim <= 1'b0;
            prim_d <= 1'b0;
            half <= 1'b0;
        end else begin
            prim <= cfg.host_mode ? HOST_PRIMARY_CLOCK_INPUT : PCI_CLK_IN;
            prim_d <= prim;
            if (prim && !prim_d)
                half <= !half;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PCI_SYNC_OUT <= 1'b0;
        end else begin
            PCI_SYNC_OUT <= cfg.host_primary_clock_input_div ? half : prim;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_BUS_OUT; gi++) begin : g_bus
            always_ff @(posedge CLK or posedge RST) begin
                if (RST)
                    BUS_CLOCK_OUTPUT_N[gi] <= 1'b0;
                else
                    BUS_CLOCK_OUTPUT_N[gi] <= output_clock_control_register[gi] ? half : prim;
            end
        end
    endgenerate

    // Memory pair: one toggle per cycle gives half the controller rate
    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            MEMORY_BUS_CLOCK_PAIR <= 2'h0;
        else if (!gate)
            MEMORY_BUS_CLOCK_PAIR <= 2'h0;
        else
            MEMORY_BUS_CLOCK_PAIR <= {MEMORY_BUS_CLOCK_PAIR[0], !MEMORY_BUS_CLOCK_PAIR[0]};
    end

    // Local bus divider; code three falls back to eight
    assign lb_bit = (local_bus_clock_config_register == 2'h0) ? lb_cnt[0] : (local_bus_clock_config_register == 2'h1) ? lb_cnt[1] : lb_cnt[2];
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            lb_cnt <= '0;
            LOCAL_BUS_SYNC_OUTPUT <= 1'b0;
            LOCAL_BUS_CLOCK_OUTPUTS <= '0;
        end else begin
            lb_cnt <= gate ? lb_cnt + 3'h1 : 3'h0;
            LOCAL_BUS_SYNC_OUTPUT <= gate && lb_bit;
            LOCAL_BUS_CLOCK_OUTPUTS <= {3{gate && lb_bit}};
        end
    end

    // Unit enables: the two-bit code is the divisor, so zero stops the unit
    generate
        for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
            logic [1:0] cnt;
            logic [1:0] code;
            assign code = system_clock_config_register[2*gi +: 2];
            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    cnt <= 2'h0;
                    UNIT_CLK_EN[gi] <= 1'b0;
                end else begin
                    cnt <= (!gate || cnt >= code - 2'h1) ? 2'h0 : cnt + 2'h1;
                    UNIT_CLK_EN[gi] <= gate && code != `SCGU_UNIT_OFF && cnt == 2'h0;
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK or posedge RST) begin
        if (RST)
            PCI_DMA_CLK_EN <= 1'b0;
        else
            PCI_DMA_CLK_EN <= gate && system_clock_config_register[`SCGU_SYSTEM_CLOCK_CONFIG_REGISTER_PCI_BIT];
    end

    // AXI write: address and data taken together, one write in flight
    assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID;
    assign S_AXI_AWREADY = wr_go;
    assign S_AXI_WREADY = wr_go;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            output_clock_control_register <= '0;
            system_clock_config_register <= `SCGU_SYSTEM_CLOCK_CONFIG_REGISTER_RESET;
            local_bus_clock_config_register <= `SCGU_LOCAL_BUS_CLOCK_CONFIG_REGISTER_RESET;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `SCGU_RESP_OKAY;
        end else begin
            if (S_AXI_BVALID && S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
            if (wr_go) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= `SCGU_RESP_OKAY;
                if (S_AXI_AWADDR == `SCGU_OUTPUT_CLOCK_CONTROL_REGISTER_OFFSET) begin
                    if (S_AXI_WSTRB[0])
                        output_clock_control_register <= S_AXI_WDATA[NUM_BUS_OUT-1:0];
                end else if (S_AXI_AWADDR == `SCGU_SYSTEM_CLOCK_CONFIG_REGISTER_OFFSET) begin
                    if (S_AXI_WSTRB[0])
                        system_clock_config_register[7:0] <= S_AXI_WDATA[7:0];
                    if (S_AXI_WSTRB[1])
                        system_clock_config_register[10:8] <= S_AXI_WDATA[10:8];
                end else if (S_AXI_AWADDR == `SCGU_LOCAL_BUS_CLOCK_CONFIG_REGISTER_OFFSET) begin
                    if (S_AXI_WSTRB[0])
                        local_bus_clock_config_register <= S_AXI_WDATA[1:0];
                end else if (S_AXI_AWADDR != `SCGU_STAT_OFFSET) begin
                    S_AXI_BRESP <= `SCGU_RESP_SLVERR;
                end
            end
        end
    end

    // AXI read
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    always_comb begin
        rd_word = 32'h0;
        rd_ok = 1'b1;
        if (S_AXI_ARADDR == `SCGU_OUTPUT_CLOCK_CONTROL_REGISTER_OFFSET)
            rd_word[NUM_BUS_OUT-1:0] = output_clock_control_register;
        else if (S_AXI_ARADDR == `SCGU_SYSTEM_CLOCK_CONFIG_REGISTER_OFFSET)
            rd_word[10:0] = system_clock_config_register;
        else if (S_AXI_ARADDR == `SCGU_LOCAL_BUS_CLOCK_CONFIG_REGISTER_OFFSET)
            rd_word[1:0] = local_bus_clock_config_register;
        else if (S_AXI_ARADDR == `SCGU_STAT_OFFSET)
            rd_word[17:0] = {state, gate, SYSTEM_PLL_MULTIPLIER_FIELD_RESERVED, cfg};
        else
            rd_ok = 1'b0;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= `SCGU_RESP_OKAY;
        end else if (S_AXI_ARVALID && !S_AXI_RVALID) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= rd_word;
            S_AXI_RRESP <= rd_ok ? `SCGU_RESP_OKAY : `SCGU_RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
        end
    end

    // Code and gate must hold over the whole window, or a rewrite would trip it
    sequence third_run_s;
        (system_clock_config_register[1:0] == `SCGU_UNIT_THIRD && gate) [*3];
    endsequence

    gated_off_a: assert property (@(posedge CLK) disable iff (RST)
        !gate |=> UNIT_CLK_EN == '0 && !PCI_DMA_CLK_EN)
        else $error("derived enable while gated");
    cfg_held_a: assert property (@(posedge CLK) disable iff (RST)
        state != scgu_pkg::SCGU_LATCH |=> $stable(cfg))
        else $error("config changed after latch");
    third_rate_a: assert property (@(posedge CLK) disable iff (RST)
        system_clock_config_register[1:0] == `SCGU_UNIT_THIRD && gate ##1 UNIT_CLK_EN[0] ##0 third_run_s
        |=> UNIT_CLK_EN[0] && !$past(UNIT_CLK_EN[0]) && !$past(UNIT_CLK_EN[0], 2))
        else $error("third rate wrong");
    pci_full_a: assert property (@(posedge CLK) disable iff (RST)
        gate && system_clock_config_register[`SCGU_SYSTEM_CLOCK_CONFIG_REGISTER_PCI_BIT] |=> PCI_DMA_CLK_EN)
        else $error("bus complex not at full rate");
    csb_ratio_a: assert property (@(posedge CLK) disable iff (RST)
        state == scgu_pkg::SCGU_RUN |-> CSB_RATIO == (cfg.host_primary_clock_input_div ? 6'(2 * mult) : 6'(mult)))
        else $error("system bus ratio wrong");
    system_pll_multiplier_field_x16_a: assert property (@(posedge CLK) disable iff (RST)
        state == scgu_pkg::SCGU_RUN && cfg.system_pll_multiplier_field == `SCGU_SYSTEM_PLL_MULTIPLIER_FIELD_X16 |-> CSB_RATIO[4:0] == 5'h10
        || CSB_RATIO == 6'h20)
        else $error("code zero not sixteen");
    sync_path_a: assert property (@(posedge CLK) disable iff (RST)
        ##1 PCI_SYNC_OUT == (($past(cfg.host_primary_clock_input_div)) ? $past(half) : $past(prim)))
        else $error("sync output path wrong");
    bus_out_a: assert property (@(posedge CLK) disable iff (RST)
        output_clock_control_register[0] |=> BUS_CLOCK_OUTPUT_N[0] == $past(half))
        else $error("bus output mux wrong");
    host_src_a: assert property (@(posedge CLK) disable iff (RST)
        cfg.host_mode && $stable(cfg) |=> prim == $past(HOST_PRIMARY_CLOCK_INPUT))
        else $error("host source not selected");
    mem_pair_a: assert property (@(posedge CLK) disable iff (RST)
        gate [*2] |-> MEMORY_BUS_CLOCK_PAIR[0] != MEMORY_BUS_CLOCK_PAIR[1]
        ##1 !gate || $changed(MEMORY_BUS_CLOCK_PAIR))
        else $error("memory pair not toggling");
    lb_half_a: assert property (@(posedge CLK) disable iff (RST)
        local_bus_clock_config_register == 2'h0 && gate [*3] |-> LOCAL_BUS_SYNC_OUTPUT != $past(LOCAL_BUS_SYNC_OUTPUT))
        else $error("local bus half rate wrong");
endmodule // scgu_top

// ==== hw/scgu_params.svh ====
// Offsets, field positions, reset values and encodings of the clock unit.
// Assumes inclusion by bare name from the top module and the bench.
`ifndef SCGU_PARAMS_SVH
`define SCGU_PARAMS_SVH

// Register byte offsets
`define SCGU_OUTPUT_CLOCK_CONTROL_REGISTER_OFFSET 8'h00
`define SCGU_SYSTEM_CLOCK_CONFIG_REGISTER_OFFSET 8'h04
`define SCGU_LOCAL_BUS_CLOCK_CONFIG_REGISTER_OFFSET 8'h08
`define SCGU_STAT_OFFSET 8'h0C

// Reset config word low field positions
`define SCGU_SYSTEM_PLL_MULTIPLIER_FIELD_LSB 0
`define SCGU_CORE_LSB 4
`define SCGU_MEMORY_CLOCK_MODE_BIT_BIT 8
`define SCGU_LOCAL_BUS_CLOCK_MODE_BIT_BIT 9

// Built-in reset configuration option
`define SCGU_BUILTIN_RESET_CONFIG_WORD_LOW 16'h0034

// System clock config register layout
`define SCGU_SYSTEM_CLOCK_CONFIG_REGISTER_PCI_BIT 10
`define SCGU_SYSTEM_CLOCK_CONFIG_REGISTER_RESET 11'h7FF

// Unit clock codes: value is the divisor, zero means off
`define SCGU_UNIT_OFF 2'h0
`define SCGU_UNIT_THIRD 2'h3

// Local bus divide field reset value (divide by two)
`define SCGU_LOCAL_BUS_CLOCK_CONFIG_REGISTER_RESET 2'h0

// System PLL multiplier codes
`define SCGU_SYSTEM_PLL_MULTIPLIER_FIELD_X16 4'h0
`define SCGU_SYSTEM_PLL_MULTIPLIER_FIELD_RSVD 4'h1
`define SCGU_MULT_16 5'h10

// AXI responses
`define SCGU_RESP_OKAY 2'h0
`define SCGU_RESP_SLVERR 2'h2

`endif

// ==== hw/scgu_pkg.sv ====
// Types shared by the clock generation unit.
// Assumes the params header is on the include path.
package scgu_pkg;
    typedef struct packed {
        logic host_mode;
        logic host_primary_clock_input_div;
        logic [3:0] system_pll_multiplier_field;
        logic [3:0] core;
        logic memory_clock_mode_bit;
        logic local_bus_clock_mode_bit;
    } scgu_cfg_type;

    typedef enum logic [3:0] {
        SCGU_HOLD = 4'h1,
        SCGU_LATCH = 4'h2,
        SCGU_WAIT_LOCK = 4'h4,
        SCGU_RUN = 4'h8
    } scgu_state_type;
endpackage

// ==== sim/scgu_src_model.sv ====
// Far-side model: host oscillator, bus clock pin and system PLL lock.
// Assumes clk is the bench clock; sources are given as sampled levels.
`timescale 1ns/1ps
module scgu_src_model #(
    parameter int LOCK_DELAY = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Mode strap
    input wire logic host_mode,
    // Far-side pins
    output logic host_clk,
    output logic pci_clk,
    output logic pll_lock
);
    int ph4;
    int ph6;
    int lock_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph4 <= 0;
            ph6 <= 0;
        end else begin
            ph4 <= (ph4 + 1) % 4;
            ph6 <= (ph6 + 1) % 6;
        end
    end
    // Distinct rates on both pins, so a wrong source choice shows up
    always_comb begin
        if (host_mode) begin
            host_clk = ph4 < 2;
            pci_clk = ph6 < 3;
        end else begin
            host_clk = 1'b0;
            pci_clk = ph4 < 2;
        end
    end
    // Late lock keeps the gated window long enough to observe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_cnt <= 0;
            pll_lock <= 1'b0;
        end else begin
            lock_cnt <= lock_cnt + 1;
            pll_lock <= lock_cnt >= LOCK_DELAY;
        end
    end
endmodule // scgu_src_model

// ==== sim/scgu_top_tb.sv ====
// Self-checking bench for the clock generation unit.
// Assumes the design files and the far-side model are compiled first.
`timescale 1ns/1ps
`include "scgu_params.svh"
module scgu_top_tb;
    logic CLK, RST, HOST_MODE, INPUT_HALVING_SELECT, USE_BUILTIN_CONFIG;
    logic host_clk, pci_clk, pll_lock, pci_sync, dma_en, rsv, lsync, probe;
    logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [15:0] rcw;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [1:0] bresp, rresp, mem_pair, ddr_r, lbiu_r;
    logic [4:0] bus_out, unit_en;
    logic [2:0] lclk;
    logic [5:0] csb_r;
    logic [3:0] core_m;
    logic [33:0] expq[$];
    int mismatches, total_checks, cycles, sel;

    scgu_top uut (.CLK(CLK), .RST(RST), .HOST_MODE(HOST_MODE),
        .HOST_PRIMARY_CLOCK_INPUT(host_clk), .PCI_CLK_IN(pci_clk),
        .INPUT_HALVING_SELECT(INPUT_HALVING_SELECT), .RESET_CONFIG_WORD_LOW(rcw),
        .USE_BUILTIN_CONFIG(USE_BUILTIN_CONFIG), .PLL_LOCK(pll_lock),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PCI_SYNC_OUT(pci_sync),
        .BUS_CLOCK_OUTPUT_N(bus_out), .MEMORY_BUS_CLOCK_PAIR(mem_pair),
        .LOCAL_BUS_SYNC_OUTPUT(lsync), .LOCAL_BUS_CLOCK_OUTPUTS(lclk),
        .UNIT_CLK_EN(unit_en), .PCI_DMA_CLK_EN(dma_en), .CSB_RATIO(csb_r),
        .CORE_MULT(core_m), .DDR_RATIO(ddr_r), .LBIU_RATIO(lbiu_r), .SYSTEM_PLL_MULTIPLIER_FIELD_RESERVED(rsv));
    scgu_src_model src (.clk(CLK), .rst(RST), .host_mode(HOST_MODE), .host_clk(host_clk),
        .pci_clk(pci_clk), .pll_lock(pll_lock));

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    always_comb begin
        case (sel)
            0: probe = pci_sync;
            1: probe = bus_out[0];
            2: probe = bus_out[1];
            3: probe = lclk[0];
            4: probe = unit_en[0];
            6: probe = lsync;
            default: probe = mem_pair[0] ^ mem_pair[1];
        endcase
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Counts rising edges and high samples of the probed output
    task automatic measure(input int s, input int n, output int rises, output int highs);
        logic last;
        sel = s;
        rises = 0;
        highs = 0;
        @(posedge CLK);
        last = probe;
        repeat (n) begin
            @(posedge CLK);
            if (probe === 1'b1 && last === 1'b0) rises++;
            if (probe === 1'b1) highs++;
            last = probe;
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge CLK);
            if (awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge CLK);
        check({30'h0, bresp}, {30'h0, resp});
        bready <= 1'b0;
        @(posedge CLK);
    endtask
    // Expected read result is queued; the monitor below compares it
    task automatic axi_read(input logic [7:0] a, input logic [33:0] exp);
        expq.push_back(exp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge CLK); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge CLK);
        rready <= 1'b0;
        @(posedge CLK);
    endtask
    always @(posedge CLK) begin
        if (rvalid === 1'b1 && rready === 1'b1 && expq.size() > 0) begin
            check({30'h0, rresp}, {30'h0, expq[0][33:32]});
            check(rdata, expq[0][31:0]);
            void'(expq.pop_front());
        end
    end
    always @(posedge CLK) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            $display("unexpected at %0t: timeout", $time);
            wrap_up();
        end
    end
    task automatic reg_tests();
        int r, h;
        axi_read(8'h00, 34'h0);
        axi_read(8'h04, 34'h7FF);
        axi_read(8'h08, 34'h0);
        axi_read(8'h10, {`SCGU_RESP_SLVERR, 32'h0});
        axi_read(8'h0C, 34'h22C16);
        axi_write(8'h10, 32'h1, `SCGU_RESP_SLVERR);
        axi_write(8'h00, 32'h1, `SCGU_RESP_OKAY);
        axi_read(8'h00, 34'h1);
        measure(1, 48, r, h);
        check(r, 6);
        measure(2, 48, r, h);
        check(r, 12);
        for (int c = 0; c < 4; c++) begin
            axi_write(8'h04, 32'h7FC | c, `SCGU_RESP_OKAY);
            repeat (4) @(posedge CLK);
            measure(4, 30, r, h);
            check(h, (c == 0) ? 0 : 30 / c);
        end
        axi_write(8'h04, 32'h3FF, `SCGU_RESP_OKAY);
        repeat (3) @(posedge CLK);
        check({31'h0, dma_en}, 32'h0);
        for (int c = 0; c < 3; c++) begin
            axi_write(8'h08, c, `SCGU_RESP_OKAY);
            repeat (16) @(posedge CLK);
            measure(3, 32, r, h);
            check(r, 16 >> c);
            measure(6, 32, r, h);
            check(r, 16 >> c);
        end
    endtask

    initial begin
        int r, h, m, k;
        logic [15:0] w, ew;
        logic dv;
        RST = 1'b1;
        {HOST_MODE, INPUT_HALVING_SELECT, USE_BUILTIN_CONFIG} = 3'h4;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        rcw = 16'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        seed = 32'h0D77;
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            case (i)
                0: w = 16'h0150;
                1: w = {6'h0, 2'h2, seed[7:4], 4'h2 + 4'(seed[3:0] % 14)};
                2: w = 16'hFFFF;
                default: w = 16'h0371;
            endcase
            dv = (i == 0 || i == 3);
            ew = (i == 2) ? 16'h0034 : w;
            m = (ew[3:0] == 4'h0) ? 16 : int'(ew[3:0]);
            // Chosen straps keep the derived clocks in range
            HOST_MODE <= (i != 1);
            INPUT_HALVING_SELECT <= dv;
            USE_BUILTIN_CONFIG <= (i == 2);
            rcw <= w;
            RST <= 1'b1;
            repeat (12) @(posedge CLK);
            RST <= 1'b0;
            repeat (5) @(posedge CLK);
            check({31'h0, dma_en}, 32'h0);
            check({30'h0, mem_pair}, 32'h0);
            k = 0;
            while (dma_en !== 1'b1 && k < 100) begin
                @(posedge CLK);
                k++;
            end
            repeat (4) @(posedge CLK);
            check({31'h0, dma_en}, 32'h1);
            check({31'h0, rsv}, {31'h0, ew[3:0] == 4'h1});
            if (ew[3:0] != 4'h1) check({26'h0, csb_r}, (1 + dv) * m);
            check({28'h0, core_m}, {28'h0, ew[7:4]});
            check({30'h0, ddr_r}, 1 + ew[8]);
            check({30'h0, lbiu_r}, 1 + ew[9]);
            measure(0, 48, r, h);
            check(r, dv ? 6 : 12);
            measure(5, 48, r, h);
            check(h, 48);
            if (i == 0) reg_tests();
        end
        wrap_up();
    end
endmodule // scgu_top_tb
